// [pfr_pkg.sv]
// Purpose: constants and types of the polarimeter stream framer
// Assumes: 200 MHz sys_clk
// Notes: register offsets are byte addresses
// Operation
// - Sample rate 1, 10 or 100 kHz
// - One trigger pulse per sample when enabled
// - Trigger pulse width in microseconds
// - Gain 1-5, auto tracking, one-shot optimize
// - 4-byte header plus 10..1020 data bytes
// - Header bytes all ones
// - Datapoint is five 16-bit fields in order
// - Ends unsigned, middle three signed
// - Internal triggering sends full 1024-byte packets
// - External triggering may send shorter packets
// - USB: commands 0x01, replies 0x81, stream 0x82
// - TCP: commands 5025, stream 5026
// - Same packet layout on both links
// - Stream link selectable, USB after reset
package pfr_pkg;
  localparam int          SYS_CLK_HZ    = 200_000_000;
  localparam int          CLK_NS        = 5;
  localparam int          US_NS         = 1000;
  localparam int          CYC_PER_US    = US_NS / CLK_NS;
  localparam int          RATE_1K_HZ    = 1_000;
  localparam int          RATE_10K_HZ   = 10_000;
  localparam int          RATE_100K_HZ  = 100_000;
  localparam int          DIV_1K_CYC    = SYS_CLK_HZ / RATE_1K_HZ;
  localparam int          DIV_10K_CYC   = SYS_CLK_HZ / RATE_10K_HZ;
  localparam int          DIV_100K_CYC  = SYS_CLK_HZ / RATE_100K_HZ;
  localparam int          HDR_BYTES     = 4;
  localparam int          POINT_BYTES   = 10;
  localparam int          MAX_PAYLOAD   = 1020;
  localparam int          MAX_POINTS    = MAX_PAYLOAD / POINT_BYTES;
  localparam logic [7:0]  HDR_BYTE      = 8'hFF;
  localparam logic [7:0]  USB_EP_CMD    = 8'h01;
  localparam logic [7:0]  USB_EP_REPLY  = 8'h81;
  localparam logic [7:0]  USB_EP_STREAM = 8'h82;
  localparam logic [15:0] TCP_PORT_CMD  = 16'h13A1;
  localparam logic [15:0] TCP_PORT_STRM = 16'h13A2;
  localparam logic [2:0]  GAIN_MIN      = 3'h1;
  localparam logic [2:0]  GAIN_MAX      = 3'h5;
  localparam logic [2:0]  GAIN_RST      = 3'h1;
  localparam logic [15:0] PWIDTH_RST    = 16'h0001;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_PWIDTH    = 8'h04;
  localparam logic [7:0]  REG_GAIN      = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0C;
  // CTRL fields
  localparam int          CTRL_RUN      = 0;
  localparam int          CTRL_RATE     = 1;
  localparam int          CTRL_TRIG_EN  = 3;
  localparam int          CTRL_EXT      = 4;
  localparam int          CTRL_LAN      = 5;
  // GAIN fields
  localparam int          GAIN_AUTO     = 3;
  localparam int          GAIN_OPT      = 4;
  // STATUS fields
  localparam int          STAT_OVF      = 0;
  localparam int          STAT_GAIN     = 1;
  localparam int          STAT_TRIG     = 4;
  localparam int          STAT_BUSY     = 5;
  localparam int          STAT_PKTS     = 16;

  typedef enum logic [1:0] {PFR_RATE_1K, PFR_RATE_10K, PFR_RATE_100K} pfr_rate_t;

  typedef struct packed {
    logic [15:0] power;
    logic signed [15:0] circ;
    logic signed [15:0] diag;
    logic signed [15:0] horiz;
    logic [15:0] total;
  } pfr_point_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pfr_bus_t;
endpackage : pfr_pkg

// [pfr_fifo.sv]
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty are exact
`timescale 1ns/10ps
module pfr_fifo #(
  parameter int W     = 80,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  import pfr_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } pfr_fifo_st_t;

  pfr_fifo_st_t st;
  pfr_fifo_st_t next_st;
  logic         push;
  logic         pop;

  assign in_ready  = st.cnt != (AW+1)'(DEPTH);
  assign out_valid = st.cnt != '0;
  assign out_data  = st.mem[st.rp];

  always_comb begin
    next_st = st;
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : pfr_fifo

// [pfr_framer.sv]
// Purpose: sample pacing, trigger output, gain control and stream packet framing
// Assumes: front end on sys_clk; ext_trig is an asynchronous pin
// Notes: stream bytes leave with valid/ready; sink may stall
`timescale 1ns/10ps
module pfr_framer #(
  parameter int DIV_1K     = pfr_pkg::DIV_1K_CYC,
  parameter int DIV_10K    = pfr_pkg::DIV_10K_CYC,
  parameter int DIV_100K   = pfr_pkg::DIV_100K_CYC,
  parameter int US_CYC     = pfr_pkg::CYC_PER_US,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Register port
  input  wire pfr_pkg::pfr_bus_t  bus,
  output logic [31:0]             rdata,
  // Measurement front end
  input  wire pfr_pkg::pfr_point_t meas,
  input  wire logic               pow_high,
  input  wire logic               pow_low,
  output logic                    samp_strobe,
  output logic [2:0]              gain_level,
  // Trigger pins
  input  wire logic               ext_trig,
  output logic                    trig_out,
  // Stream bytes
  output logic [7:0]              strm_data,
  output logic                    strm_valid,
  output logic                    strm_last,
  output logic                    strm_lan,
  output logic [15:0]             strm_dest,
  input  wire logic               strm_ready
);
  import pfr_pkg::*;

  typedef enum logic [1:0] {PFR_IDLE, PFR_HDR, PFR_DATA} pfr_fsm_t;

  typedef struct packed {
    logic        run;
    pfr_rate_t   rate;
    logic        trig_en;
    logic        ext;
    logic        lan;
    logic [15:0] dest;
    logic [15:0] pwidth;
    logic [2:0]  gain;
    logic        auto_g;
    logic        opt;
    logic [17:0] div;
    logic [23:0] tcnt;
    logic        trig;
    logic        sync1;
    logic        sync2;
    logic        ext_q;
    logic        strobe;
    logic        ovf;
    logic [15:0] pkts;
    pfr_fsm_t    fsm;
    logic [1:0]  hidx;
    logic [3:0]  bidx;
    logic [6:0]  pts;
    logic [79:0] shift;
    logic [7:0]  data;
    logic        valid;
    logic        last;
    logic [31:0] rdata;
  } pfr_st_t;

  pfr_st_t     st;
  pfr_st_t     next_st;
  logic        fin_ready;
  logic        fout_valid;
  logic [79:0] fout_data;
  logic        fpop;
  logic        tick;
  logic        can_emit;
  logic [17:0] div_end;
  logic        pt_end;

  pfr_fifo #(
    .W     (80),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (meas),
    .in_valid  (tick),
    .in_ready  (fin_ready),
    .out_data  (fout_data),
    .out_valid (fout_valid),
    .out_ready (fpop)
  );

  always_comb begin
    next_st  = st;
    tick     = 1'b0;
    fpop     = 1'b0;
    pt_end   = 1'b0;
    can_emit = !st.valid || strm_ready;
    unique case (st.rate)
      PFR_RATE_10K:  div_end = 18'(DIV_10K - 1);
      PFR_RATE_100K: div_end = 18'(DIV_100K - 1);
      default:       div_end = 18'(DIV_1K - 1);
    endcase

    // Register port
    if (bus.wr) begin
      unique case (bus.addr)
        REG_CTRL: begin
          next_st.run     = bus.wdata[CTRL_RUN];
          if (bus.wdata[CTRL_RATE +: 2] != 2'h3) begin
            next_st.rate = pfr_rate_t'(bus.wdata[CTRL_RATE +: 2]);
          end
          next_st.trig_en = bus.wdata[CTRL_TRIG_EN];
          next_st.ext     = bus.wdata[CTRL_EXT];
          next_st.lan     = bus.wdata[CTRL_LAN];
        end
        REG_PWIDTH: next_st.pwidth = bus.wdata[15:0];
        REG_GAIN: begin
          if (bus.wdata[2:0] >= GAIN_MIN && bus.wdata[2:0] <= GAIN_MAX) begin
            next_st.gain = bus.wdata[2:0];
          end
          next_st.auto_g = bus.wdata[GAIN_AUTO];
          next_st.opt    = bus.wdata[GAIN_OPT];
        end
        REG_STATUS: begin
          if (bus.wdata[STAT_OVF]) begin
            next_st.ovf = 1'b0;
          end
        end
        default: ;
      endcase
    end
    next_st.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        REG_CTRL: begin
          next_st.rdata[CTRL_RUN]       = st.run;
          next_st.rdata[CTRL_RATE +: 2] = st.rate;
          next_st.rdata[CTRL_TRIG_EN]   = st.trig_en;
          next_st.rdata[CTRL_EXT]       = st.ext;
          next_st.rdata[CTRL_LAN]       = st.lan;
        end
        REG_PWIDTH: next_st.rdata[15:0] = st.pwidth;
        REG_GAIN: begin
          next_st.rdata[2:0]       = st.gain;
          next_st.rdata[GAIN_AUTO] = st.auto_g;
          next_st.rdata[GAIN_OPT]  = st.opt;
        end
        REG_STATUS: begin
          next_st.rdata[STAT_OVF]       = st.ovf;
          next_st.rdata[STAT_GAIN +: 3] = st.gain;
          next_st.rdata[STAT_TRIG]      = st.trig;
          next_st.rdata[STAT_BUSY]      = st.fsm != PFR_IDLE;
          next_st.rdata[STAT_PKTS +: 16] = st.pkts;
        end
        default: ;
      endcase
    end

    // Destination follows the link choice in the same edge
    next_st.dest = next_st.lan ? TCP_PORT_STRM : {8'h00, USB_EP_STREAM};

    // Sample pacing: internal divider or synchronised external edge
    next_st.sync1 = ext_trig;
    next_st.sync2 = st.sync1;
    next_st.ext_q = st.sync2;
    if (!st.run || st.div >= div_end) begin
      next_st.div = '0;
    end else begin
      next_st.div = st.div + 1'b1;
    end
    if (st.run) begin
      if (st.ext) begin
        tick = st.sync2 && !st.ext_q;
      end else begin
        tick = st.div == div_end;
      end
    end
    next_st.strobe = tick;
    if (tick && !fin_ready) begin
      next_st.ovf = 1'b1;
    end

    // Trigger output
    if (!st.trig_en) begin
      next_st.tcnt = '0;
      next_st.trig = 1'b0;
    end else if (tick && st.pwidth != '0) begin
      next_st.tcnt = 24'(st.pwidth * US_CYC) - 1'b1;
      next_st.trig = 1'b1;
    end else if (st.tcnt != '0) begin
      next_st.tcnt = st.tcnt - 1'b1;
    end else begin
      next_st.trig = 1'b0;
    end

    // Gain tracking per sample
    if (tick && (st.auto_g || st.opt)) begin
      if (pow_high && st.gain > GAIN_MIN) begin
        next_st.gain = st.gain - 1'b1;
      end else if (pow_low && st.gain < GAIN_MAX) begin
        next_st.gain = st.gain + 1'b1;
      end
      next_st.opt = 1'b0;
    end

    // Framing
    if (can_emit) begin
      next_st.valid = 1'b0;
      next_st.last  = 1'b0;
      unique case (st.fsm)
        PFR_IDLE: begin
          if (fout_valid && st.run) begin
            next_st.fsm  = PFR_HDR;
            next_st.hidx = '0;
            next_st.pts  = '0;
            next_st.bidx = '0;
          end
        end
        PFR_HDR: begin
          next_st.data  = HDR_BYTE;
          next_st.valid = 1'b1;
          next_st.hidx  = st.hidx + 1'b1;
          if (st.hidx == 2'(HDR_BYTES - 1)) begin
            next_st.fsm = PFR_DATA;
          end
        end
        PFR_DATA: begin
          if (st.bidx == '0) begin
            if (fout_valid) begin
              fpop          = 1'b1;
              next_st.data  = fout_data[7:0];
              next_st.shift = fout_data >> 8;
              next_st.valid = 1'b1;
              next_st.bidx  = 4'h1;
            end
          end else begin
            next_st.data  = st.shift[7:0];
            next_st.shift = st.shift >> 8;
            next_st.valid = 1'b1;
            next_st.bidx  = st.bidx + 1'b1;
            pt_end        = st.bidx == 4'(POINT_BYTES - 1);
            if (pt_end) begin
              next_st.bidx = '0;
              next_st.pts  = st.pts + 1'b1;
              if (st.pts == 7'(MAX_POINTS - 1)) begin
                next_st.last = 1'b1;
              end else if (st.ext && !fout_valid) begin
                next_st.last = 1'b1;
              end
              if (next_st.last) begin
                next_st.fsm  = PFR_IDLE;
                next_st.pkts = st.pkts + 1'b1;
              end
            end
          end
        end
        default: next_st.fsm = PFR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st        <= '0;
      st.rate   <= PFR_RATE_1K;
      st.gain   <= GAIN_RST;
      st.pwidth <= PWIDTH_RST;
      st.fsm    <= PFR_IDLE;
      st.dest   <= {8'h00, USB_EP_STREAM};
    end else begin
      st <= next_st;
    end
  end

  assign rdata       = st.rdata;
  assign samp_strobe = st.strobe;
  assign gain_level  = st.gain;
  assign trig_out    = st.trig;
  assign strm_data   = st.data;
  assign strm_valid  = st.valid;
  assign strm_last   = st.last;
  assign strm_lan    = st.lan;
  assign strm_dest   = st.dest;
endmodule : pfr_framer

// [pfr_framer_props.sv]
// Purpose: port checks on the stream framer
// Assumes: bound into every pfr_framer
// Notes: CTRL and PWIDTH shadows follow bus writes
`timescale 1ns/10ps
module pfr_framer_props
  import pfr_pkg::*;
#(
  parameter int US_CYC = 2
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Register port
  input wire pfr_pkg::pfr_bus_t bus,
  // Front end and trigger
  input wire logic              samp_strobe,
  input wire logic [2:0]        gain_level,
  input wire logic              trig_out,
  // Stream
  input wire logic [7:0]        strm_data,
  input wire logic              strm_valid,
  input wire logic              strm_last,
  input wire logic              strm_lan,
  input wire logic [15:0]       strm_dest,
  input wire logic              strm_ready
);
  logic [10:0] pos;
  logic [31:0] hi_cnt;
  logic        trig_en_sh;
  logic [15:0] pw_sh;
  logic        lan_sh;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pos <= 11'h0;
      hi_cnt <= 32'h0;
      trig_en_sh <= 1'b0;
      pw_sh <= PWIDTH_RST;
      lan_sh <= 1'b0;
    end else begin
      if (strm_valid && strm_ready) pos <= strm_last ? 11'h0 : pos + 11'h1;
      hi_cnt <= trig_out ? hi_cnt + 32'h1 : 32'h0;
      if (bus.wr && bus.addr == REG_CTRL) trig_en_sh <= bus.wdata[CTRL_TRIG_EN];
      if (bus.wr && bus.addr == REG_PWIDTH) pw_sh <= bus.wdata[15:0];
      if (bus.wr && bus.addr == REG_CTRL) lan_sh <= bus.wdata[CTRL_LAN];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_hdr_all_ones: assert property (strm_valid && pos < 11'h4 |-> strm_data == HDR_BYTE)
    else $error("header byte not all ones");
  a_pkt_len_ok: assert property (strm_valid && strm_last |-> pos >= 11'h00d && pos <= 11'h3ff
    && (pos - 11'h3) % 11'h00a == 11'h0) else $error("packet length wrong");
  a_stall_hold: assert property (strm_valid && !strm_ready |=> strm_valid && $stable(strm_data)
    && $stable(strm_last)) else $error("stream byte changed while stalled");
  a_trig_off_low: assert property (!trig_en_sh && !$past(trig_en_sh) |-> !trig_out)
    else $error("trigger high while disabled");
  a_trig_rise_sample: assert property ($rose(trig_out) |-> samp_strobe)
    else $error("trigger pulse without sample");
  a_trig_width_us: assert property ($fell(trig_out) && trig_en_sh |-> hi_cnt == pw_sh * US_CYC)
    else $error("trigger pulse width wrong");
  a_gain_in_range: assert property (gain_level >= GAIN_MIN && gain_level <= GAIN_MAX)
    else $error("gain level out of range");
  a_link_dest: assert property (strm_lan == lan_sh
    && strm_dest == (lan_sh ? TCP_PORT_STRM : {8'h00, USB_EP_STREAM})) else $error("stream destination wrong");
  c_pkt_end: cover property (strm_valid && strm_ready && strm_last);
  c_trig: cover property ($rose(trig_out));
  c_lan: cover property (strm_lan && strm_valid);
endmodule : pfr_framer_props

bind pfr_framer pfr_framer_props #(.US_CYC(US_CYC)) props_u (.sys_clk(sys_clk), .rst(rst), .bus(bus),
  .samp_strobe(samp_strobe), .gain_level(gain_level), .trig_out(trig_out), .strm_data(strm_data),
  .strm_valid(strm_valid), .strm_last(strm_last), .strm_lan(strm_lan), .strm_dest(strm_dest),
  .strm_ready(strm_ready));

// [pfr_host_sink.sv]
// Purpose: host side of the stream, stalls at random
// Assumes: one byte taken per valid and ready
// Notes: pos tells header bytes from payload
`timescale 1ns/10ps
module pfr_host_sink (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Stream
  input  wire logic        strm_valid,
  input  wire logic        strm_last,
  output logic             strm_ready,
  // Receive view
  output logic             got,
  output logic             is_hdr,
  output logic [10:0]      pos
);
  int seed = 32'h1b17_0f5c;
  assign got = strm_valid && strm_ready;
  assign is_hdr = pos < 11'h4;
  always @(posedge sys_clk) begin
    strm_ready <= rst ? 1'b0 : ($random(seed) % 4 != 0);
    if (rst) pos <= 11'h0;
    else if (got) pos <= strm_last ? 11'h0 : pos + 11'h1;
  end
endmodule : pfr_host_sink

// [tb_top.sv]
// Purpose: self-checking bench of the stream framer
// Assumes: shortened sample dividers and microsecond count
// Notes: payload bytes are scored against a queue
`timescale 1ns/10ps
module tb_top;
  import pfr_pkg::*;
  localparam int D1 = 80, D2 = 40, D3 = 20, USC = 2;
  int          divs [3] = '{D1, D2, D3};
  logic        sys_clk = 1'b0, rst = 1'b1, pow_high = 1'b0, pow_low = 1'b0, ext_trig = 1'b0;
  logic        samp_strobe, trig_out, strm_valid, strm_last, strm_lan, strm_ready, got, is_hdr;
  pfr_bus_t    bus = '0;
  pfr_point_t  meas = '0;
  logic [31:0] rdata;
  logic [2:0]  gain_level;
  logic [7:0]  strm_data;
  logic [15:0] strm_dest;
  logic [10:0] pos;
  logic [7:0]  q [$];
  int          n_mismatch = 0, checked = 0, seed = 32'h1b17_0f5c, exp_len = 1024, n, c, n_hi = 0, h0;
  pfr_framer #(.DIV_1K(D1), .DIV_10K(D2), .DIV_100K(D3), .US_CYC(USC), .FIFO_DEPTH(4)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .meas(meas), .pow_high(pow_high),
    .pow_low(pow_low), .samp_strobe(samp_strobe), .gain_level(gain_level), .ext_trig(ext_trig),
    .trig_out(trig_out), .strm_data(strm_data), .strm_valid(strm_valid), .strm_last(strm_last),
    .strm_lan(strm_lan), .strm_dest(strm_dest), .strm_ready(strm_ready));
  pfr_host_sink host_u (.sys_clk(sys_clk), .rst(rst), .strm_valid(strm_valid), .strm_last(strm_last),
    .strm_ready(strm_ready), .got(got), .is_hdr(is_hdr), .pos(pos));
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) bus.rd <= 1'b0;
    #1 check(rdata, e);
  endtask : rd_chk
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (!samp_strobe && k < 1000);
  endtask : gap
  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge sys_clk) ext_trig <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_trig <= 1'b0;
      repeat (60) @(posedge sys_clk);
    end
  endtask : pulses
  // Trigger high cycles, for pulse widths
  always @(posedge sys_clk) n_hi <= n_hi + int'(trig_out);
  // Note each sample's bytes, then offer a fresh one
  always @(posedge sys_clk) begin
    if (samp_strobe) begin
      for (int i = 0; i < 80; i += 8) q.push_back(meas[i+:8]);
      meas <= pfr_point_t'({$random(seed), $random(seed), $random(seed)});
    end
  end
  always @(posedge sys_clk) begin
    if (got && is_hdr) check(strm_data, HDR_BYTE);
    else if (got) check(strm_data, q.size() > 0 ? q.pop_front() : 8'hxx);
    if (got && strm_last) check(pos + 11'h1, exp_len);
  end
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(REG_PWIDTH, 32'h1);
    rd_chk(8'h10, 32'h0);
    check(strm_dest, {8'h00, USB_EP_STREAM});
    check(strm_lan, 1'b0);
    check(gain_level, GAIN_RST);
    n = 1;
    for (int g = 0; g < 8; g++) begin
      wr(REG_GAIN, g);
      if (g >= 1 && g <= 5) n = g;
      rd_chk(REG_GAIN, n);
    end
    check(gain_level, 3'h5);
    wr(REG_PWIDTH, 32'h2);
    for (int r = 0; r < 3; r++) begin
      wr(REG_CTRL, 32'h9 | (r << 1));
      gap(c);
      gap(c);
      gap(c);
      check(c, divs[r]);
    end
    // Slow rate, so no sample trails the packet end into external mode
    wr(REG_CTRL, 32'h9);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(got && strm_last) && n < 20000);
    check(got && strm_last, 1'b1);
    wr(REG_CTRL, 32'h19);
    exp_len = 14;
    pulses(3);
    wr(REG_CTRL, 32'h39);
    repeat (2) @(posedge sys_clk);
    check(strm_lan, 1'b1);
    check(strm_dest, TCP_PORT_STRM);
    h0 = n_hi;
    pulses(1);
    check(n_hi - h0, 2 * USC);
    wr(REG_CTRL, 32'h31);
    h0 = n_hi;
    pulses(2);
    check(n_hi - h0, 0);
    wr(REG_CTRL, 32'h19);
    pow_high <= 1'b1;
    wr(REG_GAIN, 32'h3);
    pulses(2);
    check(gain_level, 3'h3);
    wr(REG_GAIN, 32'hb);
    pulses(3);
    check(gain_level, 3'h1);
    pow_high <= 1'b0;
    pow_low <= 1'b1;
    pulses(2);
    check(gain_level, 3'h3);
    wr(REG_GAIN, 32'h13);
    pulses(3);
    check(gain_level, 3'h4);
    rd_chk(REG_STATUS, 32'h0011_0008);
    repeat (100) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule : tb_top
